// File: hdl/adc_conversion_control.sv
`timescale 1ns/1ps
`default_nettype none
`include "adc_ctrl_defines.svh"
// Operation
// - the selected channel pin is forced to analog input
// - latch and direction writes do not drive a claimed pin
// - reading a claimed pin gives 0, or the latch when direction set
// - unselected channel pins stay ordinary port I/O
// - high reference and ground codes are not decoded; they convert the input picked by their low two bits
// - any status/control write other than the power-off code starts a conversion
// - a conversion takes 16 to 17 ADC clocks
// - on completion store result and flag or interrupt on the same edge
// - continuous mode overwrites the result unread or not
// - continuous conversions restart until the mode bit is cleared
// - done flag stays set until control write or data read
// - with interrupts on and flag clear, request a CPU interrupt
// - with interrupts on and flag set, a DMA request instead
// - with interrupts on, the flag is not a completion indicator
// - in wait mode conversion runs and its interrupt wakes the CPU
// - stop mode abandons any conversion in progress
// - continuous conversions, or a start still pending, resume when stop mode ends
// - one of four channels is routed to the converter
// - codes 0..3 pick pins, all ones powers off
// - prescale divides by 1, 2, 4, 8 or 16
module adc_conversion_control import adc_ctrl_pkg::*; #(
	parameter int CHANNELS = 4
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [31:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [31:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic bus_clk_tick,
	input wire logic osc_clk_tick,
	input wire logic comparator_high,
	input wire logic stop_mode,
	input wire logic [CHANNELS-1:0] port_b_pin_in,
	output logic [CHANNELS-1:0] port_b_pin_out,
	output logic [CHANNELS-1:0] port_b_pin_oe_n,
	output logic [CHANNELS-1:0] port_b_analog_pins,
	output logic [1:0] selected_analog_input,
	output logic [7:0] dac_trial_code,
	output logic cpu_irq_req,
	output logic dma_irq_req
);
	// ======================================================
	// register bus
	logic [7:0] wr_addr_r;
	logic aw_held_r, w_held_r;
	logic [7:0] wr_data_r;
	logic do_write, do_read;
	logic [7:0] sc_r, clk_r, result_r;
	logic [CHANNELS-1:0] latch_r, dir_r;
	conv_state_t state_r;
	logic [7:0] sar_r;
	logic [2:0] bit_idx_r;
	logic [3:0] tick_cnt_r;
	logic [4:0] div_cnt_r;
	logic adc_tick;
	logic start_pend_r;
	logic conv_done;

	// decode of the channel code into a one-hot pin claim
	function automatic logic [CHANNELS-1:0] claim_of(input logic [4:0] ch);
		logic [CHANNELS-1:0] m;
		m = '0;
		if (ch <= `CH_LAST_PIN)
			m[ch[1:0]] = 1'b1;
		return m;
	endfunction

	assign do_write = aw_held_r && w_held_r && !s_axi_bvalid;
	assign do_read = s_axi_arvalid && s_axi_arready;

	// write side: address and data held separately, either order
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_r <= 1'b0;
			w_held_r <= 1'b0;
			wr_addr_r <= 8'h00;
			wr_data_r <= 8'h00;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= 2'b00;
		end else begin
			s_axi_awready <= !aw_held_r && !s_axi_awready && !s_axi_bvalid;
			s_axi_wready <= !w_held_r && !s_axi_wready && !s_axi_bvalid;
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held_r <= 1'b1;
				wr_addr_r <= s_axi_awaddr[7:0];
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held_r <= 1'b1;
				wr_data_r <= s_axi_wstrb[0] ? s_axi_wdata[7:0] : 8'h00;
			end
			if (do_write) begin
				aw_held_r <= 1'b0;
				w_held_r <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= (wr_addr_r == `OFF_STATUS_CONTROL ||
					wr_addr_r == `OFF_CLOCK || wr_addr_r == `OFF_PORT_LATCH ||
					wr_addr_r == `OFF_PORT_DIR) ? 2'b00 : 2'b10;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// read side: one cycle address accept, data next cycle
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= 2'b00;
		end else begin
			s_axi_arready <= !s_axi_arready && !s_axi_rvalid &&
				s_axi_arvalid;
			if (do_read) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp <= 2'b00;
				case (s_axi_araddr[7:0])
				`OFF_STATUS_CONTROL: s_axi_rdata <= {24'h00_0000, sc_r};
				`OFF_DATA: s_axi_rdata <= {24'h00_0000, result_r};
				`OFF_CLOCK: s_axi_rdata <= {24'h00_0000, clk_r};
				`OFF_PORT_LATCH: s_axi_rdata <= {28'h000_0000, latch_r};
				`OFF_PORT_DIR: s_axi_rdata <= {28'h000_0000, dir_r};
				`OFF_PORT_READ: begin
					// claimed pin reads 0 or latch, free pins read the pad
					s_axi_rdata <= {28'h000_0000,
						(claim_of(sc_r[4:0]) & dir_r & latch_r) |
						(~claim_of(sc_r[4:0]) & port_b_pin_in)};
				end
				default: begin
					s_axi_rdata <= 32'h0000_0000;
					s_axi_rresp <= 2'b10;
				end
				endcase
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	// ======================================================
	// control registers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sc_r <= `RST_STATUS_CONTROL;
			clk_r <= `RST_CLOCK;
			latch_r <= '0;
			dir_r <= '0;
		end else begin
			if (do_write && wr_addr_r == `OFF_STATUS_CONTROL)
				sc_r[6:0] <= wr_data_r[6:0];
			if (do_write && wr_addr_r == `OFF_CLOCK)
				clk_r <= {wr_data_r[7:4], 4'h0};
			// latch keeps the value; the claim blocks it at the pad
			if (do_write && wr_addr_r == `OFF_PORT_LATCH)
				latch_r <= wr_data_r[CHANNELS-1:0];
			if (do_write && wr_addr_r == `OFF_PORT_DIR)
				dir_r <= wr_data_r[CHANNELS-1:0];
			// done flag: set wins over a clear in the same cycle
			if (conv_done && !sc_r[`SC_IRQ_EN_BIT])
				sc_r[`SC_DONE_BIT] <= 1'b1;
			else if ((do_write && wr_addr_r == `OFF_STATUS_CONTROL) ||
				(do_read && s_axi_araddr[7:0] == `OFF_DATA))
				sc_r[`SC_DONE_BIT] <= 1'b0;
		end
	end

	// ======================================================
	// pins and mux
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			port_b_pin_out <= '0;
			port_b_pin_oe_n <= '1;
			port_b_analog_pins <= '0;
			selected_analog_input <= 2'b00;
		end else begin
			port_b_analog_pins <= claim_of(sc_r[4:0]);
			selected_analog_input <= sc_r[1:0];
			port_b_pin_out <= latch_r & ~claim_of(sc_r[4:0]);
			// claimed pin never driven; others follow direction
			port_b_pin_oe_n <= ~(dir_r & ~claim_of(sc_r[4:0]));
		end
	end

	// ======================================================
	// adc clock prescaler; top bit of the field forces /16
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			div_cnt_r <= 5'h00;
		end else if (clk_r[`CLK_SRC_BIT] ? bus_clk_tick : osc_clk_tick) begin
			div_cnt_r <= div_cnt_r + 5'h01;
		end
	end
	// tick when the counted source edges reach the ratio
	assign adc_tick = (clk_r[`CLK_SRC_BIT] ? bus_clk_tick : osc_clk_tick) &&
		(clk_r[7] ? (div_cnt_r[3:0] == 4'hf) :
		(clk_r[6:5] == 2'b00) ? 1'b1 :
		(clk_r[6:5] == 2'b01) ? div_cnt_r[0] :
		(clk_r[6:5] == 2'b10) ? (div_cnt_r[1:0] == 2'b11) :
		(div_cnt_r[2:0] == 3'b111));

	// ======================================================
	// sequencer: 8 sample clocks, 8 resolve clocks, finish on next edge
	// a power-off in the finishing tick stores nothing, so flags nothing
	assign conv_done = adc_tick && state_r == CONV_FINISH && !stop_mode &&
		sc_r[4:0] != `CH_POWER_OFF;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			start_pend_r <= 1'b0;
		end else if (do_write && wr_addr_r == `OFF_STATUS_CONTROL) begin
			start_pend_r <= wr_data_r[4:0] != `CH_POWER_OFF;
		end else if (state_r == CONV_SAMPLE || sc_r[4:0] == `CH_POWER_OFF) begin
			start_pend_r <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_r <= CONV_IDLE;
			sar_r <= 8'h00;
			bit_idx_r <= 3'h7;
			tick_cnt_r <= 4'h0;
			result_r <= 8'h00;
			dac_trial_code <= 8'h00;
		end else if (stop_mode || sc_r[4:0] == `CH_POWER_OFF) begin
			// stop abandons the conversion; continuous mode or a pending
			// start picks up again once stop ends
			state_r <= CONV_IDLE;
		end else if (adc_tick) begin
			case (state_r)
			CONV_IDLE: begin
				if (start_pend_r || sc_r[`SC_CONT_BIT]) begin
					state_r <= CONV_SAMPLE;
					tick_cnt_r <= 4'h1;
				end
			end
			CONV_SAMPLE: begin
				tick_cnt_r <= tick_cnt_r + 4'h1;
				if (tick_cnt_r == 4'(`CONV_SAMPLE_CLKS - 4'h1)) begin
					state_r <= CONV_RESOLVE;
					sar_r <= 8'h80;
					dac_trial_code <= 8'h80;
					bit_idx_r <= 3'h7;
				end
			end
			CONV_RESOLVE: begin
				// keep the trial bit if the input is above the trial level
				sar_r[bit_idx_r] <= comparator_high;
				if (bit_idx_r != 3'h0) begin
					sar_r[bit_idx_r - 3'h1] <= 1'b1;
					dac_trial_code <= (sar_r & ~(8'h01 << bit_idx_r)) |
						({7'h00, comparator_high} << bit_idx_r) |
						(8'h01 << (bit_idx_r - 3'h1));
					bit_idx_r <= bit_idx_r - 3'h1;
				end else begin
					state_r <= CONV_FINISH;
				end
			end
			CONV_FINISH: begin
				result_r <= sar_r;
				// continuous mode restarts at once
				state_r <= sc_r[`SC_CONT_BIT] ? CONV_SAMPLE : CONV_IDLE;
				tick_cnt_r <= 4'h1;
			end
			default: state_r <= CONV_IDLE;
			endcase
		end
	end

	// ======================================================
	// interrupt requests held until data read or control write
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cpu_irq_req <= 1'b0;
			dma_irq_req <= 1'b0;
		end else if (conv_done && sc_r[`SC_IRQ_EN_BIT]) begin
			cpu_irq_req <= !sc_r[`SC_DONE_BIT];
			dma_irq_req <= sc_r[`SC_DONE_BIT];
		end else if ((do_write && wr_addr_r == `OFF_STATUS_CONTROL) ||
			(do_read && s_axi_araddr[7:0] == `OFF_DATA)) begin
			cpu_irq_req <= 1'b0;
			dma_irq_req <= 1'b0;
		end
	end

	// ======================================================
	// checks
	sequence stop_seen;
		stop_mode;
	endsequence
	sequence conv_idle_next;
		##1 state_r == CONV_IDLE;
	endsequence

	stop_aborts_a: assert property (@(posedge aclk) disable iff (!aresetn)
		stop_seen |-> conv_idle_next)
		else $error("stop did not abort conversion");
	done_sets_flag_a: assert property (@(posedge aclk) disable iff (!aresetn)
		conv_done && !sc_r[6] |=> sc_r[7] && result_r == $past(sar_r))
		else $error("completion not flagged");
	cpu_irq_a: assert property (@(posedge aclk) disable iff (!aresetn)
		conv_done && sc_r[6] && !sc_r[7] |=> cpu_irq_req && !dma_irq_req)
		else $error("cpu interrupt missing");
	dma_irq_a: assert property (@(posedge aclk) disable iff (!aresetn)
		conv_done && sc_r[6] && sc_r[7] |=> dma_irq_req)
		else $error("dma request missing");
	flag_clear_a: assert property (@(posedge aclk) disable iff (!aresetn)
		do_write && wr_addr_r == 8'h3c && !conv_done |=> !sc_r[7])
		else $error("flag not cleared by write");
	claim_pin_a: assert property (@(posedge aclk) disable iff (!aresetn)
		sc_r[4:0] == 5'h02 && $stable(sc_r) |=> port_b_analog_pins == 4'h4
		&& port_b_pin_oe_n[2])
		else $error("pin not claimed");
	power_off_a: assert property (@(posedge aclk) disable iff (!aresetn)
		sc_r[4:0] == 5'h1f |=> state_r == CONV_IDLE && port_b_analog_pins == 4'h0)
		else $error("converter not off");
	write_starts_a: assert property (@(posedge aclk) disable iff (!aresetn)
		do_write && wr_addr_r == 8'h3c && wr_data_r[4:0] != 5'h1f |=> start_pend_r)
		else $error("write did not arm conversion");
	continuous_a: assert property (@(posedge aclk) disable iff (!aresetn)
		conv_done && sc_r[5] |=> state_r == CONV_SAMPLE)
		else $error("continuous did not restart");

	// adc ticks between the start tick and the completing tick
	logic [4:0] conv_len_r;
	always_ff @(posedge aclk) begin
		if (!aresetn || state_r == CONV_IDLE || conv_done) begin
			conv_len_r <= 5'h00;
		end else if (adc_tick && conv_len_r != 5'h1f) begin
			conv_len_r <= conv_len_r + 5'h01;
		end
	end

	// fifteen ticks between means sixteen clocks from the start tick
	conv_len_a: assert property (@(posedge aclk) disable iff (!aresetn)
		conv_done |-> conv_len_r == 5'h0f)
		else $error("conversion length wrong");
	mux_one_a: assert property (@(posedge aclk) disable iff (!aresetn)
		$onehot0(port_b_analog_pins) && (port_b_analog_pins == '0 ||
		port_b_analog_pins[selected_analog_input]))
		else $error("mux select and pin claim disagree");
	pin_quiet_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(port_b_pin_out & port_b_analog_pins) == '0 &&
		(port_b_pin_oe_n & port_b_analog_pins) == port_b_analog_pins)
		else $error("claimed pin still driven");
	free_pin_a: assert property (@(posedge aclk) disable iff (!aresetn)
		~port_b_pin_oe_n == ($past(dir_r) & ~port_b_analog_pins))
		else $error("free pin direction lost");
	irq_clr_a: assert property (@(posedge aclk) disable iff (!aresetn)
		do_read && s_axi_araddr[7:0] == 8'h40 && !conv_done |=>
		!cpu_irq_req && !dma_irq_req)
		else $error("interrupt not cleared by data read");
	cont_res_a: assert property (@(posedge aclk) disable iff (!aresetn)
		conv_done && sc_r[5] |=> result_r == $past(sar_r))
		else $error("continuous result not stored");
	flag_ien_a: assert property (@(posedge aclk) disable iff (!aresetn)
		conv_done && sc_r[6] && !sc_r[7] |=> !sc_r[7])
		else $error("flag set with interrupts enabled");
endmodule
`default_nettype wire

// File: shared/adc_ctrl_defines.svh
`ifndef ADC_CTRL_DEFINES_SVH
`define ADC_CTRL_DEFINES_SVH
// register byte addresses
`define OFF_STATUS_CONTROL 8'h3c
`define OFF_DATA 8'h40
`define OFF_CLOCK 8'h44
`define OFF_PORT_LATCH 8'h48
`define OFF_PORT_DIR 8'h4c
`define OFF_PORT_READ 8'h50
// status/control fields
`define SC_DONE_BIT 7
`define SC_IRQ_EN_BIT 6
`define SC_CONT_BIT 5
`define SC_CH_MSB 4
`define SC_CH_LSB 0
`define CH_POWER_OFF 5'h1f
`define CH_HIGH_REF 5'h1d
`define CH_GROUND 5'h1e
`define CH_LAST_PIN 5'h03
// clock register fields
`define CLK_DIV_MSB 7
`define CLK_DIV_LSB 5
`define CLK_SRC_BIT 4
// reset values
`define RST_STATUS_CONTROL 8'h1f
`define RST_CLOCK 8'h00
// conversion timing in adc clocks; full and zero result codes
`define CONV_SAMPLE_CLKS 4'h8
`define CONV_TOTAL_CLKS 5'h10
`define RESULT_FULL 8'hff
`define RESULT_ZERO 8'h00
`endif

// File: shared/adc_ctrl_pkg.sv
package adc_ctrl_pkg;
	typedef enum logic [1:0] {
		CONV_IDLE = 2'b00,
		CONV_SAMPLE = 2'b01,
		CONV_RESOLVE = 2'b10,
		CONV_FINISH = 2'b11
	} conv_state_t;
	typedef enum logic [1:0] {
		IRQ_NONE = 2'b00,
		IRQ_CPU = 2'b01,
		IRQ_DMA = 2'b10
	} irq_kind_t;
endpackage

// File: verification/analog_front.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// far side: analog comparator and pad wiring
module analog_front (
	input wire logic [1:0] sel,
	input wire logic [7:0] trial,
	input wire logic [31:0] lvl,
	input wire logic [3:0] ext,
	input wire logic [3:0] pin_out,
	input wire logic [3:0] oe_n,
	output logic cmp_hi,
	output logic [3:0] pin_in
);
	// trips at or above the trial level, so the search lands on the level
	assign cmp_hi = (lvl[sel*8 +: 8] >= trial);
	// a pad shows its driver when enabled, else the outside source
	assign pin_in = (oe_n & ext) | (~oe_n & pin_out);
endmodule
`default_nettype wire

// File: verification/testbench.sv
`timescale 1ns/1ps
`default_nettype none
// ===========================
// self-checking bench
module testbench;
	logic aclk = 0;
	logic aresetn = 0;
	logic [31:0] awaddr = 0, wdata = 0, araddr = 0, rdata, rd;
	logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic awready, wready, bvalid, arready, rvalid, cirq, dirq, cmp;
	logic osc = 0, bus = 0, stop = 0;
	logic [1:0] bresp, rresp, rr, sel;
	logic [3:0] ext = 0, pin_in, pout, oen, claim, e;
	logic [7:0] trial;
	logic [31:0] lvl = 0, seed = 32'h0000_df60;
	int lv[4];
	int mismatches = 0, samples_checked = 0, cyc = 0, n, p;
	// clock, and input clock ticks of two unlike rates
	always #25 aclk = ~aclk;
	always @(posedge aclk) begin
		cyc <= cyc + 1;
		osc <= (cyc % 2 == 0);
		bus <= (cyc % 3 == 0);
	end
	adc_conversion_control i_dut (
		.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .bus_clk_tick(bus), .osc_clk_tick(osc),
		.comparator_high(cmp), .stop_mode(stop), .port_b_pin_in(pin_in),
		.port_b_pin_out(pout), .port_b_pin_oe_n(oen),
		.port_b_analog_pins(claim), .selected_analog_input(sel),
		.dac_trial_code(trial), .cpu_irq_req(cirq), .dma_irq_req(dirq)
	);
	analog_front i_afe (.sel(sel), .trial(trial), .lvl(lvl), .ext(ext),
		.pin_out(pout), .oe_n(oen), .cmp_hi(cmp), .pin_in(pin_in));
	// ===========================
	// helpers
	task automatic results;
		$display("checked %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	task automatic tmo;
		mismatches++;
		$display("MISMATCH wait_bound exp answer got none");
		results();
	endtask
	task automatic chk(input string s, input logic [31:0] x,
		input logic [31:0] g);
		samples_checked++;
		if (g !== x) begin
			mismatches++;
			$display("MISMATCH %s exp %h got %h", s, x, g);
		end
	endtask
	task automatic rng(input string s, input int lo, input int hi,
		input int g);
		samples_checked++;
		if (g < lo || g > hi) begin
			mismatches++;
			$display("MISMATCH %s exp %0d to %0d got %0d", s, lo, hi, g);
		end
	endtask
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	// reference successive approximation with integers
	function automatic int sar(input int v);
		int r;
		r = 0;
		for (int b = 7; b >= 0; b--) if (v >= (r | (1 << b))) r |= 1 << b;
		return r;
	endfunction
	task automatic setl(input int c, input logic [7:0] v);
		lvl[c*8 +: 8] <= v;
		lv[c] = v;
	endtask
	// ready is sampled mid-cycle, where registered outputs are settled
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic fa, fw, fb;
		int k;
		k = 0;
		fb = 0;
		awaddr <= {24'h0000_00, a};
		wdata <= {24'h0000_00, d};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!fb) begin
			@(negedge aclk);
			fa = awready;
			fw = wready;
			fb = (bvalid === 1'b1);
			@(posedge aclk);
			if (fa) awvalid <= 1'b0;
			if (fw) wvalid <= 1'b0;
			if (++k > 40) tmo();
		end
		bready <= 1'b0;
		@(posedge aclk);
	endtask
	task automatic rdr(input logic [7:0] a);
		logic fa, fr;
		int k;
		k = 0;
		fr = 0;
		araddr <= {24'h0000_00, a};
		arvalid <= 1'b1;
		rready <= 1'b1;
		while (!fr) begin
			@(negedge aclk);
			fa = arready;
			fr = (rvalid === 1'b1);
			rd = rdata;
			rr = rresp;
			@(posedge aclk);
			if (fa) arvalid <= 1'b0;
			if (++k > 40) tmo();
		end
		rready <= 1'b0;
		@(posedge aclk);
	endtask
	task automatic wirq(input int lim);
		n = 0;
		do begin
			@(negedge aclk);
			if (++n > lim) tmo();
		end while (cirq !== 1'b1);
		@(posedge aclk);
	endtask
	task automatic wdone;
		int k;
		k = 0;
		rd = 0;
		while (rd[7] !== 1'b1) begin
			rdr(8'h3c);
			if (++k > 60) tmo();
		end
	endtask
	// ===========================
	// main sequence
	initial begin
		repeat (12) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		rdr(8'h3c); chk("status_rst", 32'h1f, rd);
		rdr(8'h44); chk("clock_rst", 32'h0, rd);
		rdr(8'h80); chk("unmapped", 32'h2, {30'h0, rr});
		wr(8'h4c, 8'h0f);
		for (int k = 0; k < 4; k++) begin
			seed = lfsr(seed);
			wr(8'h48, seed[7:0]);
			wr(8'h3c, 8'(k));
			// pins follow the register one edge late; look mid-cycle
			@(negedge aclk);
			chk("claim", 32'h1 << k, claim);
			chk("mux_sel", k, sel);
			chk("oe_n", 32'h1 << k, oen);
			e = seed[3:0] | (4'h1 << k);
			chk("pin_out", e, pout | (4'h1 << k));
			@(posedge aclk);
			rdr(8'h50); chk("read_dir1", seed[3:0], rd);
			ext <= ~seed[3:0];
			wr(8'h4c, 8'h00);
			repeat (4) @(posedge aclk);
			e = ~seed[3:0] & ~(4'h1 << k);
			rdr(8'h50); chk("read_dir0", e, rd);
			wr(8'h4c, 8'h0f);
		end
		repeat (60) @(posedge aclk);
		for (int i = 0; i < 6; i++) begin
			seed = lfsr(seed);
			setl(i % 4, (i == 0) ? 8'hff : (i == 1) ? 8'h00 : seed[7:0]);
			p = (i < 5) ? (2 << i) : 3;
			wr(8'h44, (i < 5) ? {i[2:0], 5'h00} : 8'h10);
			wr(8'h3c, 8'h40 | 8'(i % 4));
			wirq(40 * p);
			rng("conv_cycles", 16 * p - 4, 17 * p + 4, n);
			chk("dma_irq", 0, dirq);
			rdr(8'h3c); chk("flag_ien", 32'h40 | (i % 4), rd);
			rdr(8'h40); chk("result", sar(lv[i % 4]), rd);
			@(negedge aclk);
			chk("irq_clear", 0, cirq);
			@(posedge aclk);
		end
		wr(8'h44, 8'h00);
		setl(2, seed[15:8]);
		wr(8'h3c, 8'h02);
		wdone();
		rdr(8'h3c); chk("flag_hold", 32'h82, rd);
		chk("irq_off", 0, cirq);
		rdr(8'h40); chk("result_flag", sar(lv[2]), rd);
		rdr(8'h3c); chk("flag_rd_clr", 32'h02, rd);
		wr(8'h3c, 8'h02);
		wdone();
		wr(8'h3c, 8'h1f);
		repeat (100) @(posedge aclk);
		rdr(8'h3c); chk("flag_wr_clr", 32'h1f, rd);
		setl(1, seed[23:16]);
		wr(8'h3c, 8'h21);
		wdone();
		setl(1, ~seed[23:16]);
		repeat (100) @(posedge aclk);
		rdr(8'h40); chk("cont_update", sar(lv[1]), rd);
		wr(8'h3c, 8'h01);
		repeat (100) @(posedge aclk);
		n = lv[1];
		setl(1, seed[31:24]);
		repeat (100) @(posedge aclk);
		rdr(8'h40); chk("cont_off", sar(n), rd);
		wr(8'h3c, 8'h61);
		wirq(100);
		stop <= 1'b1;
		repeat (4) @(posedge aclk);
		rdr(8'h40);
		@(posedge aclk);
		n = 0;
		repeat (150) begin
			@(negedge aclk);
			n += (cirq !== 1'b0);
		end
		@(posedge aclk);
		chk("stop_quiet", 0, n);
		stop <= 1'b0;
		wirq(100);
		rdr(8'h40); // first result after leaving stop is dropped
		wirq(100);
		rdr(8'h40); chk("after_stop", sar(lv[1]), rd);
		results();
	end
endmodule
`default_nettype wire
